// *** iolc_pins.sv ***
// pin-side model: sensors, lights and the bidir wires
// assumes the bench sets its wishes off the clock edge
`default_nettype none
module iolc_pins (
  // outside world
  input  wire logic [11:0] inp,
  input  wire logic [3:0]  differential_class_conn,
  input  wire logic [3:0]  ttl_lvl,
  input  wire logic [3:0]  ttl_en,
  input  wire logic [3:0]  pull_up,
  // design pins
  input  wire logic [3:0]  bidir_logic_line_o,
  input  wire logic [3:0]  bidir_logic_line_oe,
  output logic [3:0]       differential_class_in,
  output logic [7:0]       iso_input_line,
  output logic [3:0]       bidir_logic_line_i
);
  timeunit 1ns;
  timeprecision 100ps;
  assign differential_class_in = inp[3:0] | ~differential_class_conn;
  assign iso_input_line = inp[11:4];
  // released wire follows ttl_lvl where ttl_en is set, else settles to its resistor
  assign bidir_logic_line_i = bidir_logic_line_oe & bidir_logic_line_o |
    ~bidir_logic_line_oe & (ttl_en & ttl_lvl | ~ttl_en & pull_up);
endmodule
`default_nettype wire

// *** iolc_pkg.sv ***
// constants for the twenty-line io control block
// assumes one 200 MHz core clock; pins arrive as plain synchronous levels
// Notes on behaviour
// - status word: differential_class bits 0-3, iso in 4-11, iso out 12-15, bidir 16-19
// - selected line reports fixed class: differential, isolated or bidir
// - only bidir lines take direction: input, push-pull, sink-only, source-only
// - one invert bit per line, same on input and output paths
// - five filter strengths per input line, default is second lowest
// - differential_class and bidir filter times 50, 100, 200, 500 ns, 1 us
// - isolated input filter times 500 ns, 1, 2, 5, 10 us
// - clean input delayed by the filter time constant plus three clocks (two sync stages and the state register)
// - output mux picks user bit, strobe, camera trigger or steady low per line
// - camera triggers may feed bidir output lines only
// - input-capable state is taken after the inverter
// - output-only state is the selected source before the inverter
// - single line state follows the line selector
// - status word bit one means line logically high
// - push-pull drives low or high by state xor invert
// - sink-only drives low on zero, releases on one
// - source-only drives high on one, releases on zero
// - isolated input reads one when opto conducts, zero open
// - reset: invert off, filter second lowest, bidir input and undriven
`default_nettype none
package iolc_pkg;
  localparam int NLINES   = 20;
  localparam int DIFFERENTIAL_CLASS_LO  = 0;
  localparam int ISOI_LO  = 4;
  localparam int ISOO_LO  = 12;
  localparam int BIDI_LO  = 16;
  localparam int NDIFF    = 4;
  localparam int NISOI    = 8;
  localparam int NISOO    = 4;
  localparam int NBIDI    = 4;
  localparam int CLK_MHZ  = 200;

  typedef enum logic [1:0] {
    IOLC_CLASS_DIFFERENTIAL_CLASS = 2'h0,
    IOLC_CLASS_ISO  = 2'h1,
    IOLC_CLASS_TTL  = 2'h2
  } iolc_class_t;

  typedef enum logic [2:0] {
    IOLC_DIR_INPUT  = 3'h0,
    IOLC_DIR_PUSH   = 3'h1,
    IOLC_DIR_SINK   = 3'h2,
    IOLC_DIR_SOURCE = 3'h3,
    IOLC_DIR_OUTPUT = 3'h4
  } iolc_dir_t;

  // source choice encoding: kind in [5:4], index in [3:0]
  localparam logic [1:0] SRC_LOW  = 2'h0;
  localparam logic [1:0] SRC_USER = 2'h1;
  localparam logic [1:0] SRC_STRB = 2'h2;
  localparam logic [1:0] SRC_TRIG = 2'h3;

  localparam logic [2:0] FLT_DEFAULT = 3'h1;
  localparam int FLT_LEVELS = 5;
  // filter times in ns, lowest position first
  localparam int FAST_NS [5] = '{50, 100, 200, 500, 1000};
  localparam int SLOW_NS [5] = '{500, 1000, 2000, 5000, 10000};
  localparam int CNT_W = 16;

  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    if (c < 1) c = 1;
    return CNT_W'(c);
  endfunction
endpackage
`default_nettype wire

// *** iolc_top.sv ***
// io control logic for twenty general-purpose lines
// assumes pins synchronous-ish levels; sources come from elsewhere on chip
`default_nettype none
module iolc_top #(
  parameter int USER_W = 16,
  parameter int STRB_W = 4,
  parameter int TRIG_W = 4
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                reset,
  // configuration from software
  input  wire logic [4:0]          line_select,
  input  wire logic                polarity_invert_wr,
  input  wire logic                polarity_invert,
  input  wire logic                glitch_filter_level_wr,
  input  wire logic [2:0]          glitch_filter_level,
  input  wire logic                line_direction_setting_wr,
  input  wire logic [2:0]          line_direction_setting,
  input  wire logic                output_source_choice_wr,
  input  wire logic [5:0]          output_source_choice,
  // readback
  output logic [19:0]              all_lines_state_word,
  output logic                     single_line_state,
  output logic [1:0]               line_electrical_class,
  output logic [2:0]               line_direction_rd,
  output logic                     polarity_invert_rd,
  output logic [2:0]               glitch_filter_level_rd,
  output logic [5:0]               output_source_choice_rd,
  // internal sources
  input  wire logic [USER_W-1:0]   user_output_bits,
  input  wire logic [STRB_W-1:0]   strobe_outputs,
  input  wire logic [TRIG_W-1:0]   camera_triggers,
  // pins
  input  wire logic [3:0]          differential_class_in,
  input  wire logic [7:0]          iso_input_line,
  output logic [3:0]               iso_output_line,
  input  wire logic [3:0]          bidir_logic_line_i,
  output logic [3:0]               bidir_logic_line_o,
  output logic [3:0]               bidir_logic_line_oe
);
  localparam int N = iolc_pkg::NLINES;

  // the source index field is four bits wide, so no more than 16 per kind
  if (USER_W < 1 || USER_W > 16 || STRB_W < 1 || STRB_W > 16 ||
      TRIG_W < 1 || TRIG_W > 16) begin : g_bad_width
    $error("iolc_top: source widths must be 1 to 16");
  end

  // ****************************************
  // configuration state
  // ****************************************
  logic [N-1:0]    inv_q, inv_d;
  logic [2:0]      flt_q [N];
  logic [2:0]      flt_d [N];
  logic [2:0]      dir_q [4];
  logic [2:0]      dir_d [4];
  logic [5:0]      src_q [4+4];
  logic [5:0]      src_d [4+4];
  logic            sel_ok;
  logic            sel_bidi;
  logic            sel_out;
  logic [4:0]      osel;

  always_comb begin
    sel_ok   = line_select < 5'(N);
    sel_bidi = line_select >= 5'(iolc_pkg::BIDI_LO) && sel_ok;
    sel_out  = sel_bidi || (line_select >= 5'(iolc_pkg::ISOO_LO) &&
               line_select < 5'(iolc_pkg::BIDI_LO));
    // output slot: iso outputs 0-3, bidir 4-7
    osel = line_select - 5'(iolc_pkg::ISOO_LO);
    inv_d = inv_q;
    flt_d = flt_q;
    dir_d = dir_q;
    src_d = src_q;
    if (polarity_invert_wr && sel_ok) begin
      inv_d[line_select] = polarity_invert;
    end
    if (glitch_filter_level_wr && sel_ok &&
        glitch_filter_level < 3'(iolc_pkg::FLT_LEVELS)) begin
      flt_d[line_select] = glitch_filter_level;
    end
    if (line_direction_setting_wr && sel_bidi &&
        line_direction_setting <= iolc_pkg::IOLC_DIR_SOURCE) begin
      dir_d[osel[1:0]] = line_direction_setting;
    end
    if (output_source_choice_wr && sel_out) begin
      if (!(output_source_choice[5:4] == iolc_pkg::SRC_TRIG && !sel_bidi)) begin
        src_d[osel[2:0]] = output_source_choice;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      inv_q <= '0;
      for (int i = 0; i < N; i++) flt_q[i] <= iolc_pkg::FLT_DEFAULT;
      for (int i = 0; i < 4; i++) dir_q[i] <= iolc_pkg::IOLC_DIR_INPUT;
      for (int i = 0; i < 8; i++) src_q[i] <= '0;
    end else begin
      inv_q <= inv_d;
      flt_q <= flt_d;
      dir_q <= dir_d;
      src_q <= src_d;
    end
  end

  // ****************************************
  // input path: sync, filter, invert
  // ****************************************
  logic [N-1:0]    raw;
  logic [N-1:0]    s1_q, s2_q, flt_out_q, flt_out_d;
  logic [15:0]     cnt_q [N];
  logic [15:0]     cnt_d [N];
  logic [15:0]     lim;
  logic [7:0]      srcval;

  // receiver levels: opto on or open differential_class read as one
  assign raw = {bidir_logic_line_i, 4'h0, iso_input_line, differential_class_in};

  always_comb begin
    flt_out_d = flt_out_q;
    lim = '0;
    for (int i = 0; i < N; i++) begin
      cnt_d[i] = cnt_q[i];
      if (i >= iolc_pkg::ISOI_LO && i < iolc_pkg::ISOO_LO) begin
        lim = iolc_pkg::ns_to_cyc(iolc_pkg::SLOW_NS[flt_q[i]]);
      end else begin
        lim = iolc_pkg::ns_to_cyc(iolc_pkg::FAST_NS[flt_q[i]]);
      end
      if (s2_q[i] == flt_out_q[i]) begin
        cnt_d[i] = '0;
      end else if (cnt_q[i] + 16'h0001 >= lim) begin
        cnt_d[i] = '0;
        flt_out_d[i] = s2_q[i];
      end else begin
        cnt_d[i] = cnt_q[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      flt_out_q <= '0;
      for (int i = 0; i < N; i++) cnt_q[i] <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      flt_out_q <= flt_out_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // output path and state
  // ****************************************
  function automatic logic pick(input logic [5:0] c, input logic [15:0] u,
                                input logic [15:0] s, input logic [15:0] t);
    case (c[5:4])
      iolc_pkg::SRC_USER: pick = u[c[3:0]];
      iolc_pkg::SRC_STRB: pick = s[c[3:0]];
      iolc_pkg::SRC_TRIG: pick = t[c[3:0]];
      default:            pick = 1'b0;
    endcase
  endfunction

  logic [N-1:0] state_d, state_q;
  logic [3:0]   bo_d, boe_d, io_d;
  logic [15:0]  uw, sw, tw;

  always_comb begin
    uw = 16'(user_output_bits);
    sw = 16'(strobe_outputs);
    tw = 16'(camera_triggers);
    bo_d = '0;
    boe_d = '0;
    io_d = '0;
    srcval = '0;
    state_d = flt_out_q ^ inv_q;
    for (int k = 0; k < 8; k++) srcval[k] = pick(src_q[k], uw, sw, tw);
    for (int k = 0; k < 4; k++) begin
      // output-only state is the source level
      state_d[iolc_pkg::ISOO_LO+k] = srcval[k];
      io_d[k] = srcval[k] ^ inv_q[iolc_pkg::ISOO_LO+k];
    end
    for (int k = 0; k < 4; k++) begin
      case (dir_q[k])
        iolc_pkg::IOLC_DIR_PUSH: begin
          bo_d[k]  = srcval[4+k] ^ inv_q[iolc_pkg::BIDI_LO+k];
          boe_d[k] = 1'b1;
        end
        iolc_pkg::IOLC_DIR_SINK: begin
          bo_d[k]  = 1'b0;
          boe_d[k] = !(srcval[4+k] ^ inv_q[iolc_pkg::BIDI_LO+k]);
        end
        iolc_pkg::IOLC_DIR_SOURCE: begin
          bo_d[k]  = 1'b1;
          boe_d[k] = srcval[4+k] ^ inv_q[iolc_pkg::BIDI_LO+k];
        end
        default: begin
          bo_d[k]  = 1'b0;
          boe_d[k] = 1'b0;
        end
      endcase
    end
  end

  logic [3:0] bo_q, boe_q, io_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
      bo_q <= '0;
      boe_q <= '0;
      io_q <= '0;
    end else begin
      state_q <= state_d;
      bo_q <= bo_d;
      boe_q <= boe_d;
      io_q <= io_d;
    end
  end

  assign all_lines_state_word = state_q;
  assign iso_output_line      = io_q;
  assign bidir_logic_line_o   = bo_q;
  assign bidir_logic_line_oe  = boe_q;

  // ****************************************
  // selected-line readback
  // ****************************************
  always_comb begin
    single_line_state = sel_ok ? state_q[line_select] : 1'b0;
    polarity_invert_rd = sel_ok ? inv_q[line_select] : 1'b0;
    glitch_filter_level_rd = sel_ok ? flt_q[line_select] : '0;
    output_source_choice_rd = sel_out ? src_q[osel[2:0]] : '0;
    if (line_select < 5'(iolc_pkg::ISOI_LO)) begin
      line_electrical_class = iolc_pkg::IOLC_CLASS_DIFFERENTIAL_CLASS;
    end else if (line_select < 5'(iolc_pkg::BIDI_LO)) begin
      line_electrical_class = iolc_pkg::IOLC_CLASS_ISO;
    end else begin
      line_electrical_class = iolc_pkg::IOLC_CLASS_TTL;
    end
    if (sel_bidi) begin
      line_direction_rd = dir_q[osel[1:0]];
    end else if (sel_out) begin
      line_direction_rd = iolc_pkg::IOLC_DIR_OUTPUT;
    end else begin
      line_direction_rd = iolc_pkg::IOLC_DIR_INPUT;
    end
  end
endmodule
`default_nettype wire

// *** iolc_top_properties.sv ***
// port assertions for the io control block
// assumes binding into iolc_top; one clock domain
`default_nettype none
module iolc_chk (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // writes
  input wire logic [4:0] line_select,
  input wire logic       polarity_invert_wr,
  input wire logic       polarity_invert,
  input wire logic       glitch_filter_level_wr,
  input wire logic [2:0] glitch_filter_level,
  input wire logic       line_direction_setting_wr,
  input wire logic [2:0] line_direction_setting,
  input wire logic       output_source_choice_wr,
  input wire logic [5:0] output_source_choice,
  // readback and drivers
  input wire logic [2:0] line_direction_rd,
  input wire logic       polarity_invert_rd,
  input wire logic [2:0] glitch_filter_level_rd,
  input wire logic [5:0] output_source_choice_rd,
  input wire logic [3:0] bidir_logic_line_o,
  input wire logic [3:0] bidir_logic_line_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic [1:0] k;
  logic       bd;
  logic [2:0] flt_d;
  assign k = line_select[1:0];
  assign bd = line_select inside {[5'h10:5'h13]};
  // a level of five or more must leave the stored one alone
  assign flt_d = glitch_filter_level < 3'h5 ? glitch_filter_level
                                             : glitch_filter_level_rd;
  sequence held_s;
    ##1 $stable(line_select);
  endsequence
  property mode_p(m, ok);
    bd && line_direction_rd == m ##1
    $stable(line_select) && line_direction_rd == m |-> ok;
  endproperty
  AST_DIR_WR: assert property (
    line_direction_setting_wr && bd && line_direction_setting < 3'h4 ##0
    held_s |-> line_direction_rd == $past(line_direction_setting))
    else $error("direction not stored");
  AST_FLT_WR: assert property (
    glitch_filter_level_wr && line_select < 5'h0c ##0 held_s
    |-> glitch_filter_level_rd == $past(flt_d))
    else $error("filter level wrong");
  AST_INV_WR: assert property (
    polarity_invert_wr && line_select < 5'h14 ##0 held_s
    |-> polarity_invert_rd == $past(polarity_invert))
    else $error("invert not stored");
  AST_TRIG: assert property (
    output_source_choice_wr && output_source_choice[5:4] == 2'h3 &&
    line_select inside {[5'h0c:5'h0f]} ##0 held_s
    |-> $stable(output_source_choice_rd))
    else $error("trigger taken on isolated output");
  AST_IN: assert property (
    mode_p(3'h0, !bidir_logic_line_oe[k]))
    else $error("input mode drives");
  AST_PUSH: assert property (
    mode_p(3'h1, bidir_logic_line_oe[k]))
    else $error("push-pull not driving");
  AST_SINK: assert property (
    mode_p(3'h2, !(bidir_logic_line_oe[k] && bidir_logic_line_o[k])))
    else $error("sink-only drives high");
  AST_SRC: assert property (
    mode_p(3'h3, !bidir_logic_line_oe[k] || bidir_logic_line_o[k]))
    else $error("source-only drives low");
endmodule
bind iolc_top iolc_chk chk_i (.*);
`default_nettype wire

// *** test_io_line_control_block.sv ***
// self-checking bench for the io control block
// assumes iolc_top, its checker and the pin model
`default_nettype none
module test_io_line_control_block;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, reset, polarity_invert, e;
  logic        polarity_invert_wr, glitch_filter_level_wr;
  logic        line_direction_setting_wr, output_source_choice_wr;
  logic [4:0]  line_select;
  logic [2:0]  glitch_filter_level, line_direction_setting;
  logic [5:0]  output_source_choice, output_source_choice_rd, c;
  logic [19:0] all_lines_state_word;
  logic        single_line_state, polarity_invert_rd;
  logic [1:0]  line_electrical_class;
  logic [2:0]  line_direction_rd, glitch_filter_level_rd;
  logic [15:0] user_output_bits;
  logic [3:0]  strobe_outputs, camera_triggers, differential_class_in;
  logic [7:0]  iso_input_line;
  logic [3:0]  iso_output_line, bidir_logic_line_i, wrs, differential_class_conn;
  logic [3:0]  bidir_logic_line_o, bidir_logic_line_oe;
  logic [3:0]  ttl_lvl, ttl_en, pull_up;
  logic [11:0] inp;
  logic [31:0] rs;
  int          mismatches, total_checks, n, s, m;
  assign {polarity_invert_wr, glitch_filter_level_wr,
          line_direction_setting_wr, output_source_choice_wr} = wrs;
  iolc_top iolc_top_i (.*);
  iolc_pins iolc_pins_i (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic srcv(logic [5:0] x);
    case (x[5:4])
      2'h0: return 1'b0;
      2'h1: return user_output_bits[x[3:0]];
      2'h2: return strobe_outputs[x[1:0]];
      default: return camera_triggers[x[1:0]];
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] got, logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, want, got);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wt(int b, logic v, output int k);
    k = 0;
    while (all_lines_state_word[b] !== v && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    if (k == 3000) begin
      mismatches++;
      test_done();
    end
  endtask
  // selector settles a cycle before the write
  task automatic wr(int f, int sl, logic [5:0] v);
    @(negedge mclk);
    line_select = 5'(sl);
    @(negedge mclk);
    {polarity_invert, glitch_filter_level} = {v[0], v[2:0]};
    line_direction_setting = v[2:0];
    output_source_choice = v;
    wrs = 4'h8 >> f;
    @(negedge mclk);
    wrs = 4'h0;
  endtask
  // pulse one cycle short of the time constant, then a clean edge
  task automatic step(int b, int lm);
    logic v;
    int   k;
    v = all_lines_state_word[b];
    inp[b] = ~inp[b];
    repeat (lm - 1) @(negedge mclk);
    inp[b] = ~inp[b];
    repeat (lm + 4) @(negedge mclk);
    chk("glitch", all_lines_state_word[b], v);
    inp[b] = ~inp[b];
    wt(b, ~v, k);
    chk("latency", k, lm + 3);
  endtask
  initial begin
    {line_select, polarity_invert, glitch_filter_level, wrs} = '0;
    {line_direction_setting, output_source_choice, inp, rs} = '0;
    {user_output_bits, strobe_outputs, camera_triggers} = '0;
    {ttl_lvl, ttl_en, pull_up, mismatches, total_checks} = '0;
    {reset, differential_class_conn, rs} = {1'b1, 4'hf, 32'hec64_33ed};
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    // ****
    // power-on state
    // ****
    for (int i = 0; i < 20; i++) begin
      @(negedge mclk);
      line_select = 5'(i);
      #1;
      chk("inv", polarity_invert_rd, 0);
      chk("lvl", glitch_filter_level_rd, 1);
      chk("class", line_electrical_class, i < 4 ? 0 : i > 15 ? 2 : 1);
      chk("dir", line_direction_rd, i < 12 || i > 15 ? 0 : 4);
    end
    chk("word", all_lines_state_word, 0);
    chk("oe", bidir_logic_line_oe, 0);
    differential_class_conn = 4'hd;
    wt(1, 1'b1, n);
    chk("open", all_lines_state_word[1], 1);
    for (int l = 0; l < 5; l++) begin
      wr(1, 0, 6'(l));
      wr(1, 4, 6'(l));
      chk("lvl", glitch_filter_level_rd, l);
      step(0, iolc_pkg::FAST_NS[l] / 5);
      step(4, iolc_pkg::SLOW_NS[l] / 5);
    end
    wr(1, 4, 6'h05);
    chk("bad lvl", glitch_filter_level_rd, 4);
    wr(0, 0, 6'h01);
    wt(0, ~inp[0], n);
    chk("single", single_line_state, !inp[0]);
    for (int i = 0; i < 16; i++) begin
      s = 12 + i % 8;
      m = (i / 8 + i) % 4;
      rs = lfsr(rs);
      c = rs[5:0];
      if (s > 15 && i > 7) c[5:4] = 2'h3;
      if (s < 16 && c[5:4] == 2'h3) c[5:4] = 2'h1;
      if (c[5]) c[3:2] = 2'h0;
      @(negedge mclk);
      {user_output_bits, strobe_outputs, camera_triggers} = rs[31:8];
      e = srcv(c) ^ rs[6];
      {ttl_lvl, ttl_en, pull_up} = {{4{e}}, {4{m == 0}}, {4{m == 2}}};
      // invert taken at random from rs[6], so each pin carries source xor invert
      wr(0, s, {5'h00, rs[6]});
      wr(3, s, c);
      if (s < 16) begin
        wr(3, s, 6'h30);
        chk("refused", output_source_choice_rd, c);
        wr(2, s, 6'h01);
        chk("fixed dir", line_direction_rd, 4);
      end else
        wr(2, s, 6'(m));
      repeat (3) @(negedge mclk);
      if (s < 16)
        chk("iso out", iso_output_line[s - 12], e);
      else begin
        chk("oe", bidir_logic_line_oe[s - 16],
            m == 1 || m == 2 && !e || m == 3 && e);
        chk("wire", bidir_logic_line_i[s - 16], e);
      end
      wt(s, srcv(c), n);
      chk("state", single_line_state, srcv(c));
    end
    test_done();
  end
endmodule
`default_nettype wire
